// ### hw/eag_core.sv
// Purpose: Operand decode and effective address generation for a 16-bit core
// Assumes: Requests arrive decoded from the instruction word, one per cycle
// Notes: Results appear one cycle after the request; pointer updates land then too
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - File direct: address comes from the instruction field, no register used
// - Register direct: the selected working register is the operand, no memory
// - Indirect: pointer register value is the effective address
// - Post-modify: access at pointer, then step it and write back
// - Pre-modify: add signed step to pointer first, result is the address
// - Indexed: address is pointer plus offset register
// - Literal offset: address is pointer plus instruction literal
// - Move decodes source and destination modes apart, sharing one offset field
// - Move accepts indexed mode plus 8-bit and 16-bit literal operands
// - Dual-operand DSP class only takes registers 8 to 11 as pointers
// - Registers 8,9 go to X generator; 10,11 go to Y generator
// - DSP class indexed mode only on register 9 (X) and 11 (Y)
// - DSP class allows indirect, indexed, post-modify by 2, 4 or 6
// - Branch target formed from 16-bit signed literal
// - Timed interrupt disable operand is a 14-bit unsigned literal
// - Frame unlink uses an implied register; no-op decodes no fields
// - Each instruction class accepts only its own subset of modes
module eag_core (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	// Decoded request
	input wire logic req_valid,
	input wire eag_pkg::eag_req_type req,
	input wire logic [15:0] pc,
	// Register write from the datapath
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire logic [15:0] wr_data,
	// Result
	output logic rsp_valid,
	output eag_pkg::eag_rsp_type rsp
);

////////////////////////////////////////////////////////////////////////////////
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [15:0] wreg [eag_pkg::NUM_WREG];
	eag_pkg::eag_rsp_type rsp_next;
	logic src_wb, dst_wb, fault;
	logic [15:0] src_new, dst_new, step, offset_val, src_base, dst_base;
	logic [15:0] src_ea, dst_ea;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

////////////////////////////////////////////////////////////////////////////////
	// Mode subset per class and pointer
	function automatic logic mode_ok(eag_pkg::eag_class_type cls, logic [2:0] mode,
		logic [3:0] ptr, logic y_side);
		logic ok;
		ok = 1'b0;
		unique case (cls)
			eag_pkg::CLS_GENERAL: ok = (mode != eag_pkg::MODE_INDEXED);
			eag_pkg::CLS_MOVE: ok = 1'b1;
			eag_pkg::CLS_MAC:
			begin
				ok = y_side ? (ptr == eag_pkg::Y_PREFETCH_POINTER_A ||
					ptr == eag_pkg::Y_PREFETCH_POINTER_B) :
					(ptr == eag_pkg::X_PREFETCH_POINTER_A ||
					ptr == eag_pkg::X_PREFETCH_POINTER_B);
				if (mode == eag_pkg::MODE_INDEXED)
					ok = ok && (ptr == (y_side ? eag_pkg::Y_PREFETCH_POINTER_B :
						eag_pkg::X_PREFETCH_POINTER_B));
				else if (mode != eag_pkg::MODE_INDIRECT && mode != eag_pkg::MODE_POST_INC &&
					mode != eag_pkg::MODE_POST_DEC)
					ok = 1'b0;
			end
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction

	// Address and pointer update for one operand
	function automatic logic [32:0] operand_calc(logic [2:0] mode, logic [15:0] base,
		logic [15:0] ofs, logic [15:0] lit, logic [15:0] stp);
		logic [15:0] ea, np;
		logic wb;
		ea = base;
		np = base;
		wb = 1'b0;
		unique case (mode)
			eag_pkg::MODE_DIRECT: ea = base;
			eag_pkg::MODE_INDIRECT: ea = base;
			eag_pkg::MODE_POST_DEC:
			begin
				np = base - stp;
				wb = 1'b1;
			end
			eag_pkg::MODE_POST_INC:
			begin
				np = base + stp;
				wb = 1'b1;
			end
			eag_pkg::MODE_PRE_DEC:
			begin
				np = base - stp;
				ea = np;
				wb = 1'b1;
			end
			eag_pkg::MODE_PRE_INC:
			begin
				np = base + stp;
				ea = np;
				wb = 1'b1;
			end
			eag_pkg::MODE_INDEXED: ea = base + ofs;
			eag_pkg::MODE_LIT_OFS: ea = base + lit;
		endcase
		return {wb, np, ea};
	endfunction

////////////////////////////////////////////////////////////////////////////////
	assign src_base = wreg[req.src_ptr];
	assign dst_base = wreg[req.dst_ptr];
	// one offset field serves both operands
	assign offset_val = wreg[req.offset_idx];
	// DSP steps are 2, 4 or 6
	assign step = (req.cls == eag_pkg::CLS_MAC) ? {13'h0000, req.mac_step, 1'b0} :
		(req.byte_op ? eag_pkg::BYTE_STEP : eag_pkg::WORD_STEP);

	always_comb
	begin
		logic [32:0] s, d;
		logic mac, mv, gen;
		s = operand_calc(req.src_mode, src_base, offset_val, req.literal, step);
		d = operand_calc(req.dst_mode, dst_base, offset_val, req.literal, step);
		mac = (req.cls == eag_pkg::CLS_MAC);
		mv = (req.cls == eag_pkg::CLS_MOVE);
		gen = (req.cls == eag_pkg::CLS_GENERAL);
		src_ea = s[15:0];
		dst_ea = d[15:0];
		src_new = s[31:16];
		dst_new = d[31:16];
		// illegal mode or class gives a fault and no side effects
		fault = 1'b0;
		unique case (req.cls)
			eag_pkg::CLS_GENERAL, eag_pkg::CLS_MAC:
				fault = !mode_ok(req.cls, req.src_mode, req.src_ptr, 1'b0) ||
					!mode_ok(req.cls, req.dst_mode, req.dst_ptr, mac) ||
					(mac && req.mac_step == 2'h0);
			eag_pkg::CLS_MOVE: fault = (req.lit_kind == 2'h3);
			eag_pkg::CLS_BRANCH, eag_pkg::CLS_TIMED_INTERRUPT_DISABLE, eag_pkg::CLS_IMPLIED,
			eag_pkg::CLS_NOP, eag_pkg::CLS_FILE: fault = 1'b0;
			default: fault = 1'b1;
		endcase
		src_wb = req_valid && !fault && (mv || gen || mac) && s[32] &&
			!(mv && req.lit_kind != eag_pkg::LIT_NONE);
		dst_wb = req_valid && !fault && (mv || gen || mac) && d[32];
		rsp_next = '0;
		rsp_next.fault = fault;
		rsp_next.reg_idx = req.dst_ptr;
		if (!fault)
		begin
			unique case (req.cls)
				eag_pkg::CLS_GENERAL, eag_pkg::CLS_MOVE:
				begin
					if (mv && req.lit_kind != eag_pkg::LIT_NONE)
					begin
						// literal source replaces the source operand
						rsp_next.lit_op = 1'b1;
						rsp_next.lit_val = (req.lit_kind == eag_pkg::LIT_8) ?
							{8'h00, req.literal[eag_pkg::LIT8_W-1:0]} : req.literal;
					end
					else
					begin
						rsp_next.src_ea = src_ea;
						rsp_next.src_data = src_base;
						rsp_next.src_is_reg = (req.src_mode == eag_pkg::MODE_DIRECT);
						rsp_next.src_mem = (req.src_mode != eag_pkg::MODE_DIRECT);
					end
					rsp_next.dst_ea = dst_ea;
					rsp_next.dst_is_reg = (req.dst_mode == eag_pkg::MODE_DIRECT);
					rsp_next.dst_mem = (req.dst_mode != eag_pkg::MODE_DIRECT);
				end
				eag_pkg::CLS_MAC:
				begin
					// source is X prefetch, destination is Y prefetch
					rsp_next.src_ea = src_ea;
					rsp_next.dst_ea = dst_ea;
					rsp_next.x_sel = 1'b1;
					rsp_next.y_sel = 1'b1;
					rsp_next.src_mem = 1'b1;
					rsp_next.dst_mem = 1'b1;
				end
				// signed literal offset from the current pc
				eag_pkg::CLS_BRANCH:
				begin
					rsp_next.src_ea = pc + req.literal;
					rsp_next.lit_val = req.literal;
					rsp_next.lit_op = 1'b1;
				end
				eag_pkg::CLS_TIMED_INTERRUPT_DISABLE:
				begin
					rsp_next.lit_val = {2'h0, req.literal[eag_pkg::TIMED_INTERRUPT_DISABLE_LIT_W-1:0]};
					rsp_next.lit_op = 1'b1;
				end
				eag_pkg::CLS_IMPLIED:
				begin
					rsp_next.reg_idx = eag_pkg::FRAME_PTR_IDX;
					rsp_next.src_data = wreg[eag_pkg::FRAME_PTR_IDX];
					rsp_next.dst_is_reg = 1'b1;
				end
				eag_pkg::CLS_FILE:
				begin
					rsp_next.src_ea = req.literal;
					rsp_next.src_mem = 1'b1;
				end
				eag_pkg::CLS_NOP: rsp_next.reg_idx = 4'h0;
				default: rsp_next.fault = 1'b1;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Working registers; a datapath write beats any pointer update
	genvar gi;
	generate
		for (gi = 0; gi < eag_pkg::NUM_WREG; gi++)
		begin : g_wreg
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
					wreg[gi] <= eag_pkg::RESET_WREG;
				else if (ce)
				begin
					// data write first, then destination update, then source
					if (wr_en && wr_idx == 4'(gi))
						wreg[gi] <= wr_data;
					else if (dst_wb && req.dst_ptr == 4'(gi))
						wreg[gi] <= dst_new;
					else if (src_wb && req.src_ptr == 4'(gi))
						wreg[gi] <= src_new;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rsp_valid <= 1'b0;
			rsp <= '0;
		end
		else if (ce)
		begin
			rsp_valid <= req_valid;
			if (req_valid)
				rsp <= rsp_next;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	logic [15:0] past_src_base;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			past_src_base <= 16'h0000;
		else if (ce)
			past_src_base <= src_base;
	end

	indirect_ea_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_valid && !fault && req.cls == eag_pkg::CLS_GENERAL &&
		req.src_mode == eag_pkg::MODE_INDIRECT |=> rsp.src_ea == past_src_base)
		else $error("indirect address differs from pointer");
	post_inc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_valid && !fault && req.cls == eag_pkg::CLS_GENERAL && !req.byte_op &&
		req.src_mode == eag_pkg::MODE_POST_INC && req.dst_ptr != req.src_ptr &&
		!(wr_en && wr_idx == req.src_ptr) |=>
		rsp.src_ea == past_src_base && wreg[$past(req.src_ptr)] == past_src_base + 16'h0002)
		else $error("post increment wrong");
	pre_dec_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_valid && !fault && req.cls == eag_pkg::CLS_GENERAL && !req.byte_op &&
		req.src_mode == eag_pkg::MODE_PRE_DEC |=> rsp.src_ea == past_src_base - 16'h0002)
		else $error("pre decrement address wrong");
	direct_reg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_valid && !fault && req.cls == eag_pkg::CLS_MOVE &&
		req.lit_kind == eag_pkg::LIT_NONE && req.src_mode == eag_pkg::MODE_DIRECT |=>
		rsp.src_is_reg && !rsp.src_mem && rsp.src_data == past_src_base)
		else $error("register direct touched memory");
	mac_ptr_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_valid && req.cls == eag_pkg::CLS_MAC && req.src_ptr[3:1] != 3'h4 |=>
		rsp_valid && rsp.fault)
		else $error("bad X prefetch pointer accepted");
	mac_index_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_valid && req.cls == eag_pkg::CLS_MAC &&
		req.dst_mode == eag_pkg::MODE_INDEXED && req.dst_ptr != 4'hb |=> rsp.fault)
		else $error("Y indexed off the allowed pointer");
	gen_index_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_valid && req.cls == eag_pkg::CLS_GENERAL &&
		req.src_mode == eag_pkg::MODE_INDEXED |=> rsp.fault)
		else $error("general class took indexed mode");
	timed_interrupt_disable_lit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_valid && req.cls == eag_pkg::CLS_TIMED_INTERRUPT_DISABLE |=>
		rsp.lit_val[15:14] == 2'h0 && rsp.lit_val[13:0] == $past(req.literal[13:0]))
		else $error("interrupt disable literal wrong");
	write_prio_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && wr_en |=> wreg[$past(wr_idx)] == $past(wr_data))
		else $error("data write lost to pointer update");
	branch_tgt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ce && req_valid && req.cls == eag_pkg::CLS_BRANCH |=>
		rsp.src_ea == $past(pc) + $past(req.literal))
		else $error("branch target wrong");
endmodule
`default_nettype wire

// ### include/eag_pkg.sv
// Purpose: Shared constants and types for the effective address generator
// Assumes: 16-bit working registers, one request per cycle
// Notes: Mode codes are the three-bit operand mode field
package eag_pkg;
	localparam int DATA_W = 16;
	localparam int NUM_WREG = 16;
	// Operand mode field codes
	localparam logic [2:0] MODE_DIRECT = 3'h0;
	localparam logic [2:0] MODE_INDIRECT = 3'h1;
	localparam logic [2:0] MODE_POST_DEC = 3'h2;
	localparam logic [2:0] MODE_POST_INC = 3'h3;
	localparam logic [2:0] MODE_PRE_DEC = 3'h4;
	localparam logic [2:0] MODE_PRE_INC = 3'h5;
	localparam logic [2:0] MODE_INDEXED = 3'h6;
	localparam logic [2:0] MODE_LIT_OFS = 3'h7;
	// Literal operand kinds
	localparam logic [1:0] LIT_NONE = 2'h0;
	localparam logic [1:0] LIT_8 = 2'h1;
	localparam logic [1:0] LIT_16 = 2'h2;
	// Fixed register indices
	localparam logic [3:0] X_PREFETCH_POINTER_A = 4'h8;
	localparam logic [3:0] X_PREFETCH_POINTER_B = 4'h9;
	localparam logic [3:0] Y_PREFETCH_POINTER_A = 4'ha;
	localparam logic [3:0] Y_PREFETCH_POINTER_B = 4'hb;
	localparam logic [3:0] FRAME_PTR_IDX = 4'he;
	// Modification steps and literal widths
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] BYTE_STEP = 16'h0001;
	localparam int TIMED_INTERRUPT_DISABLE_LIT_W = 14;
	localparam int LIT8_W = 8;
	localparam logic [15:0] RESET_WREG = 16'h0000;
	typedef enum logic [7:0] {
		CLS_GENERAL = 8'h01,
		CLS_MOVE = 8'h02,
		CLS_MAC = 8'h04,
		CLS_BRANCH = 8'h08,
		CLS_TIMED_INTERRUPT_DISABLE = 8'h10,
		CLS_IMPLIED = 8'h20,
		CLS_NOP = 8'h40,
		CLS_FILE = 8'h80
	} eag_class_type;
	typedef struct packed {
		eag_class_type cls;
		logic [2:0] src_mode;
		logic [3:0] src_ptr;
		logic [2:0] dst_mode;
		logic [3:0] dst_ptr;
		logic [3:0] offset_idx;
		logic [1:0] lit_kind;
		logic [15:0] literal;
		logic [1:0] mac_step;
		logic byte_op;
	} eag_req_type;
	typedef struct packed {
		logic [15:0] src_ea;
		logic [15:0] dst_ea;
		logic [15:0] src_data;
		logic [15:0] lit_val;
		logic [3:0] reg_idx;
		logic src_mem;
		logic dst_mem;
		logic src_is_reg;
		logic dst_is_reg;
		logic lit_op;
		logic x_sel;
		logic y_sel;
		logic fault;
	} eag_rsp_type;
endpackage

// ### dv/eag_agu_model.sv
// Purpose: X and Y data address generators fed by the operand decoder
// Assumes: One result per cycle, faulted results are not read
// Notes: Counts reads so the bench can see where pointers were steered
`timescale 1ns/1ps
`default_nettype none
module eag_agu_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Results from the decoder
	input wire logic rsp_valid,
	input wire eag_pkg::eag_rsp_type rsp,
	// Traffic seen
	output logic [15:0] x_reads,
	output logic [15:0] y_reads,
	output logic [15:0] x_addr,
	output logic [15:0] y_addr
);
	//////////////////////////////////////////////////////////////////
	// X side reads
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			x_reads <= 16'h0000;
			x_addr <= 16'h0000;
		end
		else if (rsp_valid && rsp.x_sel && !rsp.fault)
		begin
			x_reads <= x_reads + 16'h0001;
			x_addr <= rsp.src_ea;
		end
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			y_reads <= 16'h0000;
			y_addr <= 16'h0000;
		end
		else if (rsp_valid && rsp.y_sel && !rsp.fault)
		begin
			y_reads <= y_reads + 16'h0001;
			y_addr <= rsp.dst_ea;
		end
	end
endmodule
`default_nettype wire

// ### dv/effective_address_generator_test.sv
// Purpose: Self-checking bench for the operand address generator
// Assumes: Requests one at a time, results read at the falling edge
// Notes: Clock enable drops once to check that rsp_valid and pointer register 4 freeze
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator_test;
	logic ref_clk, resetn, ce, req_valid, wr_en, rsp_valid;
	logic [15:0] pc, wr_data, x_reads, y_reads;
	logic [3:0] wr_idx;
	eag_pkg::eag_req_type req, r;
	eag_pkg::eag_rsp_type rsp;
	int fails, comparisons;
	eag_core u_dut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .req_valid(req_valid),
		.req(req), .pc(pc), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
		.rsp_valid(rsp_valid), .rsp(rsp));
	eag_agu_model u_agu (.ref_clk(ref_clk), .resetn(resetn), .rsp_valid(rsp_valid),
		.rsp(rsp), .x_reads(x_reads), .y_reads(y_reads), .x_addr(), .y_addr());
	always #2.5 ref_clk = ~ref_clk;
	//////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask
	function automatic eag_pkg::eag_req_type mk(input eag_pkg::eag_class_type c,
		input logic [2:0] sm, input logic [3:0] sp, input logic [15:0] lit);
		mk = '0;
		mk.cls = c;
		mk.src_mode = sm;
		mk.src_ptr = sp;
		mk.literal = lit;
	endfunction
	// Optional datapath write lands in the same cycle as the request
	task automatic issue(input eag_pkg::eag_req_type q, input logic we, input logic [3:0] wi,
		input logic [15:0] wd);
		int n;
		@(posedge ref_clk);
		req <= q;
		req_valid <= 1'b1;
		wr_en <= we;
		wr_idx <= wi;
		wr_data <= wd;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		wr_en <= 1'b0;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 8);
		if (rsp_valid !== 1'b1)
		begin
			fails++;
			$display("CHECK FAILED rsp_valid expected 1 seen %b", rsp_valid);
			tally_and_finish();
		end
	endtask
	task automatic go(input eag_pkg::eag_req_type q);
		issue(q, 1'b0, 4'h0, 16'h0000);
	endtask
	task automatic wreg(input logic [3:0] i, input logic [15:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		wr_idx <= i;
		wr_data <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] i, input logic [15:0] e);
		go(mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_DIRECT, i, 16'h0000));
		chk_word("reg", e, rsp.src_data);
	endtask
	//////////////////////////////////////////////////////////////////
	task automatic t_direct();
		wreg(4'h3, 16'h1234);
		rd(4'h3, 16'h1234);
		chk_bit("src_mem", 1'b0, rsp.src_mem);
		chk_bit("src_is_reg", 1'b1, rsp.src_is_reg);
		go(mk(eag_pkg::CLS_MOVE, eag_pkg::MODE_DIRECT, 4'h3, 16'h0000));
		chk_word("mv_reg", 16'h1234, rsp.src_data);
		go(mk(eag_pkg::CLS_FILE, 3'h0, 4'h0, 16'h0456));
		chk_word("file_ea", 16'h0456, rsp.src_ea);
		chk_bit("file_mem", 1'b1, rsp.src_mem);
	endtask
	task automatic t_modify();
		wreg(4'h4, 16'h0100);
		go(mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_POST_INC, 4'h4, 16'h0000));
		chk_word("post_ea", 16'h0100, rsp.src_ea);
		rd(4'h4, 16'h0102);
		r = mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_POST_DEC, 4'h4, 16'h0000);
		r.byte_op = 1'b1;
		go(r);
		chk_word("post_ea", 16'h0102, rsp.src_ea);
		go(mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_INDIRECT, 4'h4, 16'h0000));
		chk_word("ind_ea", 16'h0101, rsp.src_ea);
		chk_bit("ind_mem", 1'b1, rsp.src_mem);
		rd(4'h4, 16'h0101);
		wreg(4'h5, 16'h0200);
		go(mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_PRE_DEC, 4'h5, 16'h0000));
		chk_word("pre_ea", 16'h01fe, rsp.src_ea);
		go(mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_PRE_INC, 4'h5, 16'h0000));
		chk_word("pre_ea", 16'h0200, rsp.src_ea);
	endtask
	task automatic t_index();
		wreg(4'h6, 16'h1000);
		wreg(4'h7, 16'h0020);
		r = mk(eag_pkg::CLS_MOVE, eag_pkg::MODE_INDEXED, 4'h6, 16'h0000);
		r.dst_mode = eag_pkg::MODE_INDEXED;
		r.dst_ptr = 4'h6;
		r.offset_idx = 4'h7;
		go(r);
		chk_word("src_ea", 16'h1020, rsp.src_ea);
		chk_word("dst_ea", 16'h1020, rsp.dst_ea);
		go(mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_INDEXED, 4'h6, 16'h0000));
		chk_bit("fault", 1'b1, rsp.fault);
		go(mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_LIT_OFS, 4'h6, 16'h0034));
		chk_word("lit_ofs_ea", 16'h1034, rsp.src_ea);
		r.src_mode = eag_pkg::MODE_POST_INC;
		r.dst_mode = eag_pkg::MODE_INDIRECT;
		r.dst_ptr = 4'h7;
		go(r);
		chk_word("src_ea", 16'h1000, rsp.src_ea);
		chk_word("dst_ea", 16'h0020, rsp.dst_ea);
		rd(4'h6, 16'h1002);
	endtask
	task automatic t_literal();
		r = mk(eag_pkg::CLS_MOVE, eag_pkg::MODE_DIRECT, 4'h0, 16'h12ab);
		r.lit_kind = eag_pkg::LIT_8;
		go(r);
		chk_word("lit8", 16'h00ab, rsp.lit_val);
		chk_bit("lit_op", 1'b1, rsp.lit_op);
		r.lit_kind = eag_pkg::LIT_16;
		go(r);
		chk_word("lit16", 16'h12ab, rsp.lit_val);
		r.lit_kind = 2'h3;
		go(r);
		chk_bit("fault", 1'b1, rsp.fault);
	endtask
	task automatic t_mac();
		logic [15:0] x, y, n0, n1;
		x = 16'h0800;
		y = 16'h0c00;
		n0 = x_reads;
		n1 = y_reads;
		wreg(4'h8, x);
		wreg(4'ha, y);
		for (int s = 1; s <= 3; s++)
		begin
			r = mk(eag_pkg::CLS_MAC, eag_pkg::MODE_POST_INC, 4'h8, 16'h0000);
			r.dst_mode = eag_pkg::MODE_POST_INC;
			r.dst_ptr = 4'ha;
			r.mac_step = s[1:0];
			go(r);
			chk_word("x_ea", x, rsp.src_ea);
			chk_word("y_ea", y, rsp.dst_ea);
			chk_bit("x_sel", 1'b1, rsp.x_sel);
			chk_bit("y_sel", 1'b1, rsp.y_sel);
			chk_bit("fault", 1'b0, rsp.fault);
			x = x + 16'(2 * s);
			y = y + 16'(2 * s);
		end
		rd(4'h8, x);
		chk_word("x_reads", n0 + 16'h0003, x_reads);
		chk_word("y_reads", n1 + 16'h0003, y_reads);
		r.mac_step = 2'h0;
		go(r);
		chk_bit("fault", 1'b1, rsp.fault);
		rd(4'ha, y);
		r.mac_step = 2'h1;
		r.src_ptr = 4'h3;
		go(r);
		chk_bit("fault", 1'b1, rsp.fault);
		r.src_mode = eag_pkg::MODE_INDEXED;
		r.src_ptr = 4'h8;
		go(r);
		chk_bit("fault", 1'b1, rsp.fault);
		r.src_ptr = 4'h9;
		r.dst_mode = eag_pkg::MODE_INDEXED;
		r.dst_ptr = 4'hb;
		go(r);
		chk_bit("fault", 1'b0, rsp.fault);
		r.dst_ptr = 4'ha;
		go(r);
		chk_bit("fault", 1'b1, rsp.fault);
	endtask
	task automatic t_other();
		@(posedge ref_clk);
		pc <= 16'h0100;
		go(mk(eag_pkg::CLS_BRANCH, 3'h0, 4'h0, 16'hfff0));
		chk_word("target", 16'h00f0, rsp.src_ea);
		go(mk(eag_pkg::CLS_TIMED_INTERRUPT_DISABLE, 3'h0, 4'h0, 16'hffff));
		chk_word("timed_interrupt_disable_lit", 16'h3fff, rsp.lit_val);
		wreg(4'he, 16'h0abc);
		go(mk(eag_pkg::CLS_IMPLIED, 3'h0, 4'h0, 16'h0000));
		chk_word("reg_idx", 16'h000e, 16'(rsp.reg_idx));
		chk_word("implied", 16'h0abc, rsp.src_data);
		go(mk(eag_pkg::CLS_NOP, eag_pkg::MODE_INDIRECT, 4'h5, 16'hffff));
		chk_word("nop_ea", 16'h0000, rsp.src_ea);
		chk_word("nop_lit", 16'h0000, rsp.lit_val);
	endtask
	task automatic t_prio();
		wreg(4'h4, 16'h0200);
		issue(mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_POST_INC, 4'h4, 16'h0000), 1'b1,
			4'h4, 16'h5555);
		chk_word("post_ea", 16'h0200, rsp.src_ea);
		rd(4'h4, 16'h5555);
	endtask
	// A request held while the enable is low must not be taken
	task automatic t_freeze();
		@(posedge ref_clk);
		ce <= 1'b0;
		req <= mk(eag_pkg::CLS_GENERAL, eag_pkg::MODE_POST_INC, 4'h4, 16'h0000);
		req_valid <= 1'b1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk_bit("frozen_valid", 1'b0, rsp_valid);
		@(posedge ref_clk);
		req_valid <= 1'b0;
		ce <= 1'b1;
		rd(4'h4, 16'h5555);
	endtask
	//////////////////////////////////////////////////////////////////
	initial
	begin
		fails = 0;
		comparisons = 0;
		ref_clk = 1'b0;
		resetn = 1'b0;
		ce = 1'b1;
		req_valid = 1'b0;
		req = '0;
		r = '0;
		pc = 16'h0000;
		wr_en = 1'b0;
		wr_idx = 4'h0;
		wr_data = 16'h0000;
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_direct();
		t_modify();
		t_index();
		t_literal();
		t_mac();
		t_other();
		t_prio();
		t_freeze();
		tally_and_finish();
	end
endmodule
`default_nettype wire
